// >>> cpt_consts.svh
// Constants of the capacitive proximity/touch detector: offsets, field positions, timing.
// Assumes a 200 MHz core clock; all long times are kept in milliseconds.
`ifndef CPT_CONSTS_SVH
`define CPT_CONSTS_SVH

// Register byte offsets on APB
`define CPT_ADDR_BANK0        12'h000
`define CPT_ADDR_BANK3        12'h004
`define CPT_ADDR_BANK4        12'h008
`define CPT_ADDR_CTRL         12'h00c
`define CPT_ADDR_STAT         12'h010
`define CPT_ADDR_LTA          12'h014

// Reset values (all-zero means default behaviour)
`define CPT_BANK0_RST         8'h00
`define CPT_BANK4_RST         8'h00
`define CPT_CTRL_RST          4'h0

// Field positions, output/threshold bank
`define CPT_PROX_THRESHOLD_SELECT_LSB          0
`define CPT_TOUCH_THRESHOLD_SELECT_LSB          2
`define CPT_POL_BIT           5
`define CPT_OUTPUT_FUNCTION_SELECT_LSB          6
// Field positions, noise bank
`define CPT_NS_BIT            3
// Field positions, control register
`define CPT_CTRL_PMODE_LSB    0
`define CPT_CTRL_HALT_LSB     2
// Field positions, status register
`define CPT_STAT_PROX_BIT     16
`define CPT_STAT_TOUCH_BIT    17
`define CPT_STAT_ZOOM_BIT     18
`define CPT_STAT_TUNED_BIT    19

// Qualification counts
`define CPT_PROX_QUAL         3'd6
`define CPT_TOUCH_QUAL        2'd3
`define CPT_LTA_SHIFT         4

// Clock and timing
`define CPT_CLK_HZ            200000000
`define CPT_XFER_HZ           512000
`define CPT_XFER_DIV          (`CPT_CLK_HZ / `CPT_XFER_HZ)
`define CPT_MS_CYCLES         (`CPT_CLK_HZ / 1000)
`define CPT_BOOST_MS          10'd9
`define CPT_NORMAL_MS         10'd128
`define CPT_LP1_MS            10'd256
`define CPT_LP2_MS            10'd512
`define CPT_LATCH_MS          12'd4000
`define CPT_ZOOM_MS           2000
`define CPT_HALT20_MS         16'd20000
`define CPT_HALT40_MS         16'd40000
`define CPT_BUSY_GUARD        16'd4

`endif

// >>> cpt_pkg.sv
// Types of the capacitive proximity/touch detector.
// Assumes cpt_consts.svh supplies all numeric constants.
package cpt_pkg;

   typedef enum logic [1:0] {
      SEQ_WAIT   = 2'b00,
      SEQ_CHARGE = 2'b01,
      SEQ_EVAL   = 2'b10
   } cpt_seq_e;

   typedef struct packed {
      cpt_seq_e         st;
      logic [1:0]       trip_s;
      logic [1:0]       busy_s;
      logic [1:0]       tune_s;
      logic [7:0]       bank0;
      logic             noise_en;
      logic [1:0]       pmode;
      logic [1:0]       hsel;
      logic [23:0]      ms_div;
      logic             ms_tick;
      logic [9:0]       intv_ms;
      logic [15:0]      zoom_ms;
      logic [15:0]      halt_ms;
      logic             recal;
      logic [15:0]      xdiv;
      logic             xfer;
      logic [15:0]      count;
      logic [15:0]      cs;
      logic [15:0]      long_term_average;
      logic             lta_ok;
      logic [2:0]       prox_cnt;
      logic [1:0]       touch_cnt;
      logic [1:0]       ev;
      logic [1:0]       ev_prev;
      logic [1:0]       tog;
      logic [1:0]       lvl;
      logic [1:0]       pin;
      logic [1:0][11:0] latch_ms;
      logic             sample_done;
      logic [31:0]      prdata;
      logic             slverr;
   } cpt_state_s;

endpackage : cpt_pkg

// >>> cpt_detector.sv
// Capacitive proximity/touch detector: charge scheduling, count capture, detection,
// output pin styling and an APB register slave.
// Assumes an analog front end that reports the trip of the reference capacitor, an
// auto-tuning engine that reports completion, and a streamer that reports busy.
// Functional notes
// - Noise bank bit 3 enables enhanced noise suppression; other bits reserved.
// - Count sample equals transfer pulses issued before the reference capacitor trips.
// - One charge cycle per sample interval; post-sample work finishes before the next.
// - All-zero configuration bits select default behaviour.
// - Bank zero bit 5 picks output polarity, 0 low, 1 high; push-pull.
// - Active-high outputs stay high from power-on until auto tuning completes.
// - Bank zero bits 7-6 select direct, latched proximity, toggled touch, or both.
// - Direct style follows the event exactly.
// - Latch style holds the output at least the latch hold time.
// - Latch style keeps asserting while the event outlasts the hold time.
// - A new event during latch hold restarts the hold timer.
// - Toggle style inverts the output once per new event.
// - Proximity needs average minus count at or above threshold for 6 samples.
// - Bank zero bits 1-0 select proximity threshold 4, 2, 8 or 16.
// - Touch threshold is numerator over 256 times the long-term average.
// - Touch needs average minus count at or above threshold for 3 samples.
// - Bank zero bits 4-2 select numerator 72,8,24,48,96,128,160,192.
// - Boost mode starts charge cycles about every 9 ms.
// - A possible event switches to boost rate for the zoom hold time.
// - After the halt time a persistent shift recalibrates the reference.
// - Long-term average updates only while no event is detected, or at every sample with halt set to never.
// - Halt timer starts with an event; 20 s, 40 s, never or always.
//
// Design decisions made here: the APB slave port and the register addresses.
`include "cpt_consts.svh"

module cpt_detector #(
   parameter int MS_CYCLES = `CPT_MS_CYCLES,
   parameter int XFER_DIV  = `CPT_XFER_DIV,
   parameter int ZOOM_MS   = `CPT_ZOOM_MS
) (
   // Clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RESET_N,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output      logic [31:0] PRDATA,
   output      logic        PREADY,
   output      logic        PSLVERR,
   // Analog front end
   input  wire logic        TRIP,
   input  wire logic        AUTO_TUNE_DONE,
   output      logic        CHARGE_ACTIVE,
   output      logic        XFER_PULSE,
   output      logic        NOISE_SUPPRESS_EN,
   // Post-sample work
   input  wire logic        STREAM_BUSY,
   output      logic        SAMPLE_DONE,
   // Output pins
   output      logic        PROXIMITY_OUTPUT,
   output      logic        TOUCH_OUTPUT
);
   import cpt_pkg::*;

   cpt_state_s q;
   cpt_state_s d;

   function automatic logic [4:0] prox_thr(input logic [1:0] code);
      case (code)
         2'b00:   prox_thr = 5'd4;
         2'b01:   prox_thr = 5'd2;
         2'b10:   prox_thr = 5'd8;
         default: prox_thr = 5'd16;
      endcase
   endfunction : prox_thr

   function automatic logic [7:0] touch_num(input logic [2:0] code);
      case (code)
         3'b000:  touch_num = 8'd72;
         3'b001:  touch_num = 8'd8;
         3'b010:  touch_num = 8'd24;
         3'b011:  touch_num = 8'd48;
         3'b100:  touch_num = 8'd96;
         3'b101:  touch_num = 8'd128;
         3'b110:  touch_num = 8'd160;
         default: touch_num = 8'd192;
      endcase
   endfunction : touch_num

   function automatic logic [9:0] mode_ms(input logic [1:0] code);
      case (code)
         2'b00:   mode_ms = `CPT_BOOST_MS;
         2'b01:   mode_ms = `CPT_NORMAL_MS;
         2'b10:   mode_ms = `CPT_LP1_MS;
         default: mode_ms = `CPT_LP2_MS;
      endcase
   endfunction : mode_ms

   logic        tuned;
   logic        zoom_on;
   logic [9:0]  period_ms;
   logic        lta_ge;
   logic [15:0] diff;
   logic [23:0] tprod;
   logic [15:0] touch_threshold_select;
   logic        pcond;
   logic        tcond;
   logic [2:0]  pcnt_n;
   logic [1:0]  tcnt_n;
   logic        any_ev;
   logic        halt_run;
   logic [15:0] halt_lim;
   logic [15:0] step;
   logic [1:0]  rise;
   logic [1:0]  latch_en;
   logic [1:0]  toggle_en;
   logic        setup;
   logic        wr;

   always_comb begin
      d = q;
      tuned     = q.tune_s[1];
      zoom_on   = (q.zoom_ms != 16'h0000);
      // Boost rate while zoomed, otherwise the chosen power mode
      period_ms = zoom_on ? `CPT_BOOST_MS : mode_ms(q.pmode);
      lta_ge    = (q.long_term_average >= q.cs);
      diff      = lta_ge ? (q.long_term_average - q.cs) : 16'h0000;
      tprod     = 24'(touch_num(q.bank0[`CPT_TOUCH_THRESHOLD_SELECT_LSB +: 3])) * 24'(q.long_term_average);
      touch_threshold_select      = tprod[23:8];
      pcond     = lta_ge && (diff >= {11'h000, prox_thr(q.bank0[`CPT_PROX_THRESHOLD_SELECT_LSB +: 2])});
      tcond     = lta_ge && (diff >= touch_threshold_select);
      pcnt_n    = pcond ? ((q.prox_cnt == `CPT_PROX_QUAL) ? q.prox_cnt
                                                          : q.prox_cnt + 3'd1) : 3'd0;
      tcnt_n    = tcond ? ((q.touch_cnt == `CPT_TOUCH_QUAL) ? q.touch_cnt
                                                            : q.touch_cnt + 2'd1) : 2'd0;
      any_ev    = q.ev[0] | q.ev[1];
      // Never: no halt; always: touch holds the filter as long as it lasts
      halt_run  = any_ev && (q.hsel != 2'b10) && !((q.hsel == 2'b11) && q.ev[1]);
      halt_lim  = (q.hsel == 2'b00) ? `CPT_HALT20_MS : `CPT_HALT40_MS;
      step      = (q.cs >= q.long_term_average) ? ((q.cs - q.long_term_average) >> `CPT_LTA_SHIFT)
                                  : ((q.long_term_average - q.cs) >> `CPT_LTA_SHIFT);
      rise      = q.ev & ~q.ev_prev;
      latch_en  = {1'b0, q.bank0[`CPT_OUTPUT_FUNCTION_SELECT_LSB]};
      toggle_en = {q.bank0[`CPT_OUTPUT_FUNCTION_SELECT_LSB + 1], 1'b0};
      setup     = PSEL && !PENABLE;
      wr        = PSEL && PENABLE && PWRITE;

      // Input synchronisers
      d.trip_s = {q.trip_s[0], TRIP};
      d.busy_s = {q.busy_s[0], STREAM_BUSY};
      d.tune_s = {q.tune_s[0], AUTO_TUNE_DONE};

      // Millisecond time base shared by all long timers
      d.ms_tick = (q.ms_div == 24'(MS_CYCLES - 1));
      d.ms_div  = d.ms_tick ? 24'h000000 : q.ms_div + 24'h000001;
      if (q.ms_tick && q.intv_ms != 10'h3ff) begin
         d.intv_ms = q.intv_ms + 10'd1;
      end
      if (q.ms_tick && zoom_on) begin
         d.zoom_ms = q.zoom_ms - 16'h0001;
      end

      // Halt timer runs from the start of an event
      if (!halt_run) begin
         d.halt_ms = 16'h0000;
      end else if (q.ms_tick && q.halt_ms != 16'hffff) begin
         d.halt_ms = q.halt_ms + 16'h0001;
      end

      d.xfer        = 1'b0;
      d.sample_done = 1'b0;
      case (q.st)
         SEQ_WAIT: begin
            // Guard lets a streamer's busy cross the synchroniser; busy must
            // rise within two cycles of the sample-done pulse or it is missed
            if (q.xdiv != `CPT_BUSY_GUARD) begin
               d.xdiv = q.xdiv + 16'h0001;
            end
            // Streaming must be idle before a new charge cycle
            if (tuned && q.xdiv == `CPT_BUSY_GUARD && q.intv_ms >= period_ms
                && !q.busy_s[1]) begin
               d.st      = SEQ_CHARGE;
               d.intv_ms = 10'h000;
               d.count   = 16'h0000;
               d.xdiv    = 16'h0000;
            end
         end
         SEQ_CHARGE: begin
            if (q.trip_s[1] || q.count == 16'hffff) begin
               d.cs = q.count;
               d.st = SEQ_EVAL;
            end else if (q.xdiv == 16'(XFER_DIV - 1)) begin
               d.xdiv  = 16'h0000;
               d.xfer  = 1'b1;
               d.count = q.count + 16'h0001;
            end else begin
               d.xdiv = q.xdiv + 16'h0001;
            end
         end
         SEQ_EVAL: begin
            d.st          = SEQ_WAIT;
            d.sample_done = 1'b1;
            d.xdiv        = 16'h0000;
            if (!q.lta_ok || q.recal) begin
               // Reference snaps to the count, which ends any event
               d.long_term_average       = q.cs;
               d.lta_ok    = 1'b1;
               d.recal     = 1'b0;
               d.prox_cnt  = 3'd0;
               d.touch_cnt = 2'd0;
               d.ev        = 2'b00;
            end else begin
               d.prox_cnt  = pcnt_n;
               d.touch_cnt = tcnt_n;
               d.ev[0]     = (pcnt_n == `CPT_PROX_QUAL);
               d.ev[1]     = (tcnt_n == `CPT_TOUCH_QUAL);
               if (pcond || tcond) begin
                  d.zoom_ms = 16'(ZOOM_MS);
               end
               // Filter frozen during events, except with halt set to never
               if (!any_ev || q.hsel == 2'b10) begin
                  d.long_term_average = (q.cs >= q.long_term_average) ? q.long_term_average + step : q.long_term_average - step;
               end
            end
         end
         default: begin
            d.st = SEQ_WAIT;
         end
      endcase

      // Expiry set after the consume above so it is never lost
      if (halt_run && q.halt_ms >= halt_lim) begin
         d.recal   = 1'b1;
         d.halt_ms = 16'h0000;
      end

      // Output function per pin: direct, latch or toggle
      d.ev_prev = q.ev;
      for (int i = 0; i < 2; i++) begin
         // Only a latched pin arms its timer, so a style change starts clean
         if (rise[i] && latch_en[i]) begin
            d.latch_ms[i] = `CPT_LATCH_MS;
         end else if (q.ms_tick && q.latch_ms[i] != 12'h000) begin
            d.latch_ms[i] = q.latch_ms[i] - 12'h001;
         end
         if (toggle_en[i]) begin
            d.tog[i] = q.tog[i] ^ rise[i];
            d.lvl[i] = d.tog[i];
         end else if (latch_en[i]) begin
            d.lvl[i] = q.ev[i] | (q.latch_ms[i] != 12'h000) | rise[i];
         end else begin
            d.lvl[i] = q.ev[i];
         end
         // Polarity last; pins idle high until tuning is done
         d.pin[i] = !tuned ? 1'b1
                  : (q.bank0[`CPT_POL_BIT] ? q.lvl[i] : !q.lvl[i]);
      end

      // APB: read data captured in setup, writes at the access phase
      if (setup) begin
         d.slverr = 1'b0;
         case (PADDR)
            `CPT_ADDR_BANK0: d.prdata = {24'h000000, q.bank0};
            `CPT_ADDR_BANK3: d.prdata = 32'h00000000;
            `CPT_ADDR_BANK4: d.prdata = {28'h0000000, q.noise_en, 3'h0};
            `CPT_ADDR_CTRL:  d.prdata = {28'h0000000, q.hsel, q.pmode};
            `CPT_ADDR_STAT:  d.prdata = {12'h000, tuned, zoom_on, q.ev, q.cs};
            `CPT_ADDR_LTA:   d.prdata = {16'h0000, q.long_term_average};
            default: begin
               d.prdata = 32'h00000000;
               d.slverr = 1'b1;
            end
         endcase
      end
      if (wr) begin
         case (PADDR)
            `CPT_ADDR_BANK0: d.bank0 = PWDATA[7:0];
            `CPT_ADDR_BANK4: d.noise_en = PWDATA[`CPT_NS_BIT];
            `CPT_ADDR_CTRL: begin
               d.pmode = PWDATA[`CPT_CTRL_PMODE_LSB +: 2];
               d.hsel  = PWDATA[`CPT_CTRL_HALT_LSB +: 2];
            end
            default: begin
               d.bank0 = d.bank0;
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         q          <= '0;
         q.bank0    <= `CPT_BANK0_RST;
         q.noise_en <= 1'(`CPT_BANK4_RST >> `CPT_NS_BIT);
         q.pin      <= 2'b11;
      end else begin
         q <= d;
      end
   end

   assign PRDATA            = q.prdata;
   assign PREADY            = 1'b1;
   assign PSLVERR           = q.slverr;
   assign CHARGE_ACTIVE     = (q.st == SEQ_CHARGE);
   assign XFER_PULSE        = q.xfer;
   assign NOISE_SUPPRESS_EN = q.noise_en;
   assign SAMPLE_DONE       = q.sample_done;
   assign PROXIMITY_OUTPUT  = q.pin[0];
   assign TOUCH_OUTPUT      = q.pin[1];

endmodule : cpt_detector

// >>> cpt_detector_asserts.sv
// Checker for the capacitive proximity/touch detector, bound to its top ports.
// Assumes one clock domain and the APB map of cpt_consts.svh.
`include "cpt_consts.svh"

module cpt_detector_chk #(
   parameter int MS_CYCLES = `CPT_MS_CYCLES
) (
   input wire logic        CORE_CLK,
   input wire logic        RESET_N,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        AUTO_TUNE_DONE,
   input wire logic        CHARGE_ACTIVE,
   input wire logic        XFER_PULSE,
   input wire logic        NOISE_SUPPRESS_EN,
   input wire logic        STREAM_BUSY,
   input wire logic        SAMPLE_DONE,
   input wire logic        PROXIMITY_OUTPUT,
   input wire logic        TOUCH_OUTPUT
);
   timeunit 1ns;
   timeprecision 1ps;
   // Wide enough for the slowest interval at the full clock rate
   logic [31:0] gap_q;
   logic        seen_q;
   logic        chg_q;

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RESET_N);

   // Cycles since the last charge start, saturating
   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         gap_q  <= 32'h00000000;
         seen_q <= 1'b0;
         chg_q  <= 1'b0;
      end else begin
         chg_q <= CHARGE_ACTIVE;
         if (CHARGE_ACTIVE && !chg_q) begin
            gap_q  <= 32'h00000000;
            seen_q <= 1'b1;
         end else if (gap_q != 32'hffffffff) begin
            gap_q <= gap_q + 32'h00000001;
         end
      end
   end

   unmapped_err_a: assert property (PSEL && PENABLE && PADDR >= 12'h018 |-> PSLVERR)
      else $error("unmapped access without error");
   mapped_ok_a: assert property (PSEL && PENABLE && PADDR <= `CPT_ADDR_LTA
      && PADDR[1:0] == 2'b00 |-> !PSLVERR && PREADY) else $error("mapped access refused");
   noise_set_a: assert property (PSEL && PENABLE && PWRITE && PADDR == `CPT_ADDR_BANK4
      && PWDATA[3] |-> ##[1:2] NOISE_SUPPRESS_EN) else $error("noise enable not set");
   pretune_high_a: assert property (!AUTO_TUNE_DONE [*3] |-> PROXIMITY_OUTPUT && TOUCH_OUTPUT)
      else $error("pin low before tuning");
   done_pulse_a: assert property (SAMPLE_DONE |=> !SAMPLE_DONE)
      else $error("sample done longer than one cycle");
   done_after_a: assert property ($fell(CHARGE_ACTIVE) |-> ##[1:2] SAMPLE_DONE)
      else $error("no sample done after charge");
   xfer_gap_a: assert property (XFER_PULSE |=> !XFER_PULSE [*3])
      else $error("transfer pulses too close");
   busy_hold_a: assert property (STREAM_BUSY [*4] |-> !$rose(CHARGE_ACTIVE))
      else $error("charge started while busy");
   interval_min_a: assert property (CHARGE_ACTIVE && !chg_q && seen_q
      |-> gap_q >= 8 * MS_CYCLES) else $error("charge cycles too close");
endmodule : cpt_detector_chk

bind cpt_detector cpt_detector_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
   .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .AUTO_TUNE_DONE(AUTO_TUNE_DONE), .CHARGE_ACTIVE(CHARGE_ACTIVE), .XFER_PULSE(XFER_PULSE),
   .NOISE_SUPPRESS_EN(NOISE_SUPPRESS_EN), .STREAM_BUSY(STREAM_BUSY),
   .SAMPLE_DONE(SAMPLE_DONE), .PROXIMITY_OUTPUT(PROXIMITY_OUTPUT),
   .TOUCH_OUTPUT(TOUCH_OUTPUT));

// >>> cpt_sensor_model.sv
// Behavioural sense electrode, reference comparator and slow post-sample work.
// Assumes the detector's charge handshake; target sets pulses needed to trip.
module cpt_sensor_model (
   // Clock
   input  wire logic        clk,
   // Charge handshake
   input  wire logic        charge_active,
   input  wire logic        xfer_pulse,
   input  wire logic        sample_done,
   input  wire logic [15:0] target,
   output      logic        trip,
   output      logic        stream_busy,
   output      logic [15:0] pulses
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        trip_q = 1'b0;
   logic        prev_q = 1'b0;
   logic [15:0] n_q    = 16'h0000;
   logic [4:0]  busy_q = 5'h00;

   always @(posedge clk) begin
      prev_q <= charge_active;
      // Comparator drops with the charge so it is low before the next one
      trip_q <= charge_active && (trip_q || (xfer_pulse && n_q + 16'h0001 >= target));
      if (charge_active && !prev_q)
         n_q <= 16'h0000;
      else if (charge_active && xfer_pulse)
         n_q <= n_q + 16'h0001;
      // Slow streaming after every sample stalls the next charge
      if (sample_done)
         busy_q <= 5'h14;
      else if (busy_q != 5'h00)
         busy_q <= busy_q - 5'h01;
   end

   assign trip        = trip_q;
   assign stream_busy = busy_q != 5'h00;
   assign pulses      = n_q;
endmodule : cpt_sensor_model

// >>> cpt_detector_tb.sv
// Self-checking bench: APB master, read monitor, sensor model and pin checks.
// Assumes shortened timers: 1 ms is 10 cycles, transfer every 4 cycles.
`include "cpt_consts.svh"

module cpt_detector_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        CORE_CLK = 1'b0;
   logic        RESET_N = 1'b0;
   logic        PSEL = 1'b0;
   logic        PENABLE = 1'b0;
   logic        PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0;
   logic        AUTO_TUNE_DONE = 1'b0;
   logic [15:0] target = 16'd40;
   logic [31:0] PRDATA, rnd;
   logic [15:0] pulses;
   logic        PREADY, PSLVERR, TRIP, CHARGE_ACTIVE, XFER_PULSE, NOISE_SUPPRESS_EN;
   logic        STREAM_BUSY, SAMPLE_DONE, PROXIMITY_OUTPUT, TOUCH_OUTPUT;
   logic [32:0] eq[$], mq[$];
   int          fail_count = 0, n_tests = 0, seed = 18120;
   logic [11:0] cfg_addr[4] = '{`CPT_ADDR_BANK0, `CPT_ADDR_BANK3, `CPT_ADDR_BANK4,
                                `CPT_ADDR_CTRL};

   cpt_detector #(.MS_CYCLES(10), .XFER_DIV(4), .ZOOM_MS(5)) DUT (
      .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .TRIP(TRIP), .AUTO_TUNE_DONE(AUTO_TUNE_DONE),
      .CHARGE_ACTIVE(CHARGE_ACTIVE), .XFER_PULSE(XFER_PULSE),
      .NOISE_SUPPRESS_EN(NOISE_SUPPRESS_EN), .STREAM_BUSY(STREAM_BUSY),
      .SAMPLE_DONE(SAMPLE_DONE), .PROXIMITY_OUTPUT(PROXIMITY_OUTPUT),
      .TOUCH_OUTPUT(TOUCH_OUTPUT));

   cpt_sensor_model u_sensor (
      .clk(CORE_CLK), .charge_active(CHARGE_ACTIVE), .xfer_pulse(XFER_PULSE),
      .sample_done(SAMPLE_DONE), .target(target), .trip(TRIP), .stream_busy(STREAM_BUSY),
      .pulses(pulses));

   initial forever #2.5 CORE_CLK = ~CORE_CLK;

   task close_out;
      if (fail_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out

   task check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge CORE_CLK);
      PSEL    <= 1'b1;
      PWRITE  <= w;
      PADDR   <= a;
      PWDATA  <= d;
      @(posedge CORE_CLK);
      PENABLE <= 1'b1;
      do @(posedge CORE_CLK); while (PREADY !== 1'b1);
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb

   task rd(input logic [11:0] a, input logic [32:0] exp, input logic [32:0] msk);
      eq.push_back(exp & msk);
      mq.push_back(msk);
      apb(1'b0, a, 32'h0);
   endtask : rd

   // Waits n samples, lets events reach the pins, then looks at them
   task samp(input int n, input logic p, input logic t);
      repeat (n) @(posedge CORE_CLK iff SAMPLE_DONE === 1'b1);
      repeat (8) @(posedge CORE_CLK);
      check("proximity pin", PROXIMITY_OUTPUT, p);
      check("touch pin", TOUCH_OUTPUT, t);
   endtask : samp

   // Read monitor: takes the oldest note at each completed read
   always @(posedge CORE_CLK) begin
      if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) begin
         check("read", {PSLVERR, PRDATA} & mq[0], eq[0]);
         void'(eq.pop_front());
         void'(mq.pop_front());
      end
   end

   initial begin
      #400000;
      fail_count++;
      close_out();
   end

   initial begin
      repeat (3) @(posedge CORE_CLK);
      check("pins in reset", {PROXIMITY_OUTPUT, TOUCH_OUTPUT}, 2'b11);
      RESET_N <= 1'b1;
      foreach (cfg_addr[i])
         rd(cfg_addr[i], 33'h0, '1);
      rd(12'h018, 33'h1_0000_0000, '1);
      for (int i = 0; i < 4; i++) begin
         rnd = $random(seed);
         apb(1'b1, `CPT_ADDR_BANK4, rnd);
         apb(1'b1, `CPT_ADDR_BANK3, rnd);
         apb(1'b1, `CPT_ADDR_BANK0, rnd);
         repeat (2) @(posedge CORE_CLK);
         check("noise enable", NOISE_SUPPRESS_EN, rnd[3]);
         rd(`CPT_ADDR_BANK4, {29'h0, rnd[3], 3'h0}, '1);
         rd(`CPT_ADDR_BANK3, 33'h0, '1);
         rd(`CPT_ADDR_BANK0, {25'h0, rnd[7:0]}, '1);
         apb(1'b1, `CPT_ADDR_CTRL, rnd);
         rd(`CPT_ADDR_CTRL, {29'h0, rnd[3:0]}, '1);
      end
      // Back to boost rate and the shortest halt before tuning completes
      apb(1'b1, `CPT_ADDR_CTRL, 32'h0);
      // Active high, direct pins, touch numerator 96
      apb(1'b1, `CPT_ADDR_BANK0, 32'h30);
      repeat (10) @(posedge CORE_CLK);
      check("pins before tuning", {PROXIMITY_OUTPUT, TOUCH_OUTPUT}, 2'b11);
      AUTO_TUNE_DONE <= 1'b1;
      samp(4, 1'b0, 1'b0);
      rd(`CPT_ADDR_STAT, {13'h0, 4'b1000, pulses}, 33'h1_000b_ffff);
      target <= 16'd30;
      for (int k = 1; k <= 6; k++)
         samp(1, k == 6, 1'b0);
      rd(`CPT_ADDR_STAT, {13'h0, 4'b1101, 16'h0}, 33'h1_000f_0000);
      target <= 16'd40;
      samp(1, 1'b0, 1'b0);
      // Active low, latched proximity, toggled touch
      apb(1'b1, `CPT_ADDR_BANK0, 32'hd0);
      samp(1, 1'b1, 1'b1);
      target <= 16'd10;
      for (int k = 1; k <= 6; k++)
         samp(1, k < 6, k < 3);
      target <= 16'd40;
      samp(1, 1'b0, 1'b0);
      repeat (30000) @(posedge CORE_CLK);
      check("latched proximity", PROXIMITY_OUTPUT, 1'b0);
      repeat (12000) @(posedge CORE_CLK);
      check("released proximity", PROXIMITY_OUTPUT, 1'b1);
      // Change the count only between samples, never inside a charge
      @(posedge CORE_CLK iff SAMPLE_DONE === 1'b1);
      target <= 16'd10;
      samp(2, 1'b1, 1'b0);
      samp(1, 1'b1, 1'b1);
      target <= 16'd40;
      samp(1, 1'b1, 1'b1);
      close_out();
   end
endmodule : cpt_detector_tb
